// ==== rtl/fsec_pkg.sv ====
// Constants shared by the flash security gate, its clock divider and its operation timer.
// Assumes a 100 MHz bus clock and an APB register port with 32-bit data.
package fsec_pkg;

    // ============================================================
    // Register map (byte addresses, nine word slots)
    localparam logic [7:0] OFF_RATIO = 8'h00;
    localparam logic [7:0] OFF_OPTION = 8'h04;
    localparam logic [7:0] OFF_CONFIG = 8'h0c;
    localparam logic [7:0] OFF_PROTECT = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_LAST = 8'h20;

    // ============================================================
    // Field positions
    localparam int RATIO_LOADED_BIT = 7;
    localparam int PRESCALE_BIT = 6;
    localparam int RATIO_W = 6;
    localparam int OPT_BACKDOOR_UNLOCK_ENABLE_BIT = 7;
    localparam int CFG_COMPARISON_WRITE_ACCESS_BIT = 5;
    localparam int PROT_DIS_BIT = 0;
    localparam int ST_SECURE_BIT = 0;
    localparam int ST_STRAP_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_IDX_LSB = 4;

    // ============================================================
    // Values and geometry
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam logic [15:0] KEY_BASE = 16'hffb0;
    localparam int KEY_BYTES = 8;
    localparam logic [3:0] KEY_COUNT = 4'h8;
    localparam int BLOCK_LSB = 9;
    localparam int PRESCALE_W = 3;
    localparam logic [PRESCALE_W-1:0] PRESCALE_LIMIT = 3'h7;
    localparam int PULSE_W = 16;

endpackage

// ==== rtl/tick_divider.sv ====
// Divides a stream of step enables by limit plus one into single-cycle ticks.
// Assumes step_i is a one-cycle enable in the clk_i domain.
`timescale 1ns/1ns
module tick_divider #(
    parameter int W = 6
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Control
    input wire logic run_i,
    input wire logic step_i,
    input wire logic [W-1:0] limit_i,
    // Output
    output logic tick_o
);
    typedef struct packed {
        logic [W-1:0] count;
        logic tick;
    } div_state_t;

    div_state_t div_reg;
    div_state_t div_next;

    always_comb begin
        div_next = div_reg;
        div_next.tick = 1'h0;
        if (!run_i) begin
            div_next.count = '0;
        end else if (step_i) begin
            if (div_reg.count >= limit_i) begin
                div_next.count = '0;
                div_next.tick = 1'h1;
            end else begin
                div_next.count = div_reg.count + 1'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign tick_o = div_reg.tick;

    a_tick_cause: assert property (@(posedge clk_i) disable iff (reset_i)
        tick_o |-> $past(step_i) && $past(run_i))
        else $error("tick without a step");
endmodule

// ==== rtl/op_timer.sv ====
// Times one erase or program operation as a whole number of flash clock pulses.
// Assumes tick_i is the one-cycle flash clock enable.
`timescale 1ns/1ns
module op_timer
    import fsec_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Request
    input wire logic start_i,
    input wire logic [PULSE_W-1:0] pulses_i,
    input wire logic tick_i,
    // Result
    output logic busy_o,
    output logic done_o
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [PULSE_W-1:0] left;
    } op_state_t;

    op_state_t op_reg;
    op_state_t op_next;

    always_comb begin
        op_next = op_reg;
        op_next.done = 1'h0;
        if (!op_reg.busy && start_i) begin
            op_next.busy = 1'h1;
            op_next.left = pulses_i;
        end else if (op_reg.busy && tick_i) begin
            // Only whole pulses count toward the operation
            if (op_reg.left <= 16'h0001) begin
                op_next.busy = 1'h0;
                op_next.done = 1'h1;
            end else begin
                op_next.left = op_reg.left - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            op_reg <= '0;
        end else begin
            op_reg <= op_next;
        end
    end

    assign busy_o = op_reg.busy;
    assign done_o = op_reg.done;

    a_done_on_tick: assert property (@(posedge clk_i) disable iff (reset_i)
        done_o |-> $past(tick_i) && $past(busy_o))
        else $error("operation ended off a flash clock pulse");
endmodule

// ==== rtl/flash_security.sv ====
// Security gate for flash and RAM, backdoor key unlock and the flash clock divider.
// Assumes a 100 MHz bus clock, synchronous reset and an APB master for the registers.
`timescale 1ns/1ns
module flash_security
    import fsec_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic apb_debug_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Nonvolatile contents and strap
    input wire logic [7:0] nonvolatile_option_byte_i,
    input wire logic [7:0] nonvolatile_protection_byte_i,
    input wire logic [63:0] backdoor_comparison_bytes_i,
    input wire logic background_mode_select_pin_i,
    // Memory access from the cpu or debug controller
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [15:0] acc_addr_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic acc_mem_i,
    input wire logic acc_flash_i,
    input wire logic acc_secure_src_i,
    input wire logic acc_debug_i,
    input wire logic [7:0] mem_rdata_i,
    output logic mem_valid_o,
    output logic mem_write_o,
    output logic [15:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    output logic [7:0] acc_rdata_o,
    output logic acc_blocked_o,
    output logic cmd_start_o,
    // Flash operations
    input wire logic blank_check_done_i,
    input wire logic blank_check_erased_i,
    input wire logic op_start_i,
    input wire logic [PULSE_W-1:0] op_pulses_i,
    output logic flash_clk_tick_o,
    output logic op_busy_o,
    output logic op_done_o,
    // Debug permissions
    input wire logic debug_enable_req_i,
    input wire logic background_entry_req_i,
    output logic debug_enable_o,
    output logic background_active_o
);
    typedef struct packed {
        logic [7:0] ratio;
        logic [7:0] option;
        logic comparison_write_access;
        logic [7:0] protect;
        logic [3:0] key_idx;
        logic key_ok;
        logic strap_low;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic mem_valid;
        logic mem_write;
        logic [15:0] mem_addr;
        logic [7:0] mem_wdata;
        logic [7:0] acc_rdata;
        logic acc_blocked;
        logic cmd_start;
        logic debug_en;
        logic bg_active;
    } state_t;

    state_t st_reg;
    state_t st_next;
    state_t st_rst;

    logic secure;
    logic apb_setup;
    logic apb_write;
    logic blocked;
    logic key_hit;
    logic key_write;
    logic key_accept;
    logic [7:0] key_byte;
    logic [15:0] last_unprot;
    logic protected_addr;
    logic prescale_tick;
    logic div_step;
    logic div_tick;
    logic op_busy;
    logic op_done;

    // ============================================================
    // Security decode and access classification
    assign secure = (st_reg.option[1:0] != SEC_UNSECURED);
    assign apb_setup = psel_i && !penable_i;
    assign apb_write = psel_i && penable_i && pwrite_i && st_reg.pready;
    assign blocked = acc_valid_i && acc_mem_i && secure && (!acc_secure_src_i || acc_debug_i);
    assign key_hit = (acc_addr_i[15:3] == KEY_BASE[15:3]);
    assign key_write = acc_valid_i && acc_write_i && acc_flash_i && key_hit && st_reg.comparison_write_access;
    // Debug-side key writes fall through as nothing, neither compare nor command
    assign key_accept = key_write && acc_secure_src_i && !acc_debug_i;
    assign key_byte = backdoor_comparison_bytes_i[8*st_reg.key_idx[2:0] +: 8];
    // Key and option bytes share the top block, so protecting it protects them
    assign last_unprot = {st_reg.protect[7:1], {BLOCK_LSB{1'h1}}};
    assign protected_addr = !st_reg.protect[PROT_DIS_BIT] && (acc_addr_i > last_unprot);

    // ============================================================
    // Flash clock: prescaler then ratio divider
    tick_divider #(.W(PRESCALE_W)) prescaler (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .run_i(st_reg.ratio[RATIO_LOADED_BIT]),
        .step_i(1'h1),
        .limit_i(PRESCALE_LIMIT),
        .tick_o(prescale_tick)
    );

    assign div_step = st_reg.ratio[PRESCALE_BIT] ? prescale_tick : 1'h1;

    tick_divider #(.W(RATIO_W)) ratio_divider (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .run_i(st_reg.ratio[RATIO_LOADED_BIT]),
        .step_i(div_step),
        .limit_i(st_reg.ratio[RATIO_W-1:0]),
        .tick_o(div_tick)
    );

    // Operations stay off until the ratio has been written
    op_timer timer (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .start_i(op_start_i && st_reg.ratio[RATIO_LOADED_BIT]),
        .pulses_i(op_pulses_i),
        .tick_i(div_tick),
        .busy_o(op_busy),
        .done_o(op_done)
    );

    // ============================================================
    // Next state
    always_comb begin
        st_rst = '0;
        st_rst.option = nonvolatile_option_byte_i;
        st_rst.protect = nonvolatile_protection_byte_i;
        st_rst.key_ok = 1'h1;
        st_rst.strap_low = !background_mode_select_pin_i;

        st_next = st_reg;
        st_next.pready = 1'h0;
        st_next.pslverr = 1'h0;
        st_next.mem_valid = 1'h0;
        st_next.mem_write = 1'h0;
        st_next.cmd_start = 1'h0;

        // Zero-wait APB: data and error are staged during setup
        if (apb_setup) begin
            st_next.pready = 1'h1;
            st_next.prdata = '0;
            case (paddr_i)
                OFF_RATIO: st_next.prdata[7:0] = st_reg.ratio;
                OFF_OPTION: st_next.prdata[7:0] = st_reg.option;
                OFF_CONFIG: st_next.prdata[CFG_COMPARISON_WRITE_ACCESS_BIT] = st_reg.comparison_write_access;
                OFF_PROTECT: st_next.prdata[7:0] = st_reg.protect;
                OFF_STATUS: begin
                    st_next.prdata[ST_SECURE_BIT] = secure;
                    st_next.prdata[ST_STRAP_BIT] = st_reg.strap_low;
                    st_next.prdata[ST_BUSY_BIT] = op_busy;
                    st_next.prdata[ST_IDX_LSB +: 4] = st_reg.key_idx;
                end
                default: begin
                    st_next.pslverr = (paddr_i[1:0] != 2'h0) || (paddr_i > OFF_LAST);
                end
            endcase
        end

        if (apb_write) begin
            case (paddr_i)
                OFF_RATIO: begin
                    // Any first write marks the ratio loaded
                    st_next.ratio = {1'h1, pwdata_i[PRESCALE_BIT:0]};
                end
                OFF_CONFIG: begin
                    st_next.comparison_write_access = pwdata_i[CFG_COMPARISON_WRITE_ACCESS_BIT];
                    if (pwdata_i[CFG_COMPARISON_WRITE_ACCESS_BIT] && !st_reg.comparison_write_access) begin
                        st_next.key_idx = 4'h0;
                        st_next.key_ok = 1'h1;
                    end
                    if (!pwdata_i[CFG_COMPARISON_WRITE_ACCESS_BIT] && st_reg.comparison_write_access) begin
                        // A partial or wrong key leaves the code untouched
                        if (st_reg.option[OPT_BACKDOOR_UNLOCK_ENABLE_BIT] && st_reg.key_ok
                            && st_reg.key_idx == KEY_COUNT) begin
                            st_next.option[1:0] = SEC_UNSECURED;
                        end
                    end
                end
                OFF_PROTECT: begin
                    if (apb_debug_i) begin
                        st_next.protect = pwdata_i[7:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Each accepted byte must come in ascending order and match
        if (key_accept) begin
            if (st_reg.key_idx < KEY_COUNT) begin
                st_next.key_idx = st_reg.key_idx + 4'h1;
            end
            st_next.key_ok = st_reg.key_ok && (st_reg.key_idx < KEY_COUNT)
                && (acc_addr_i[2:0] == st_reg.key_idx[2:0]) && (acc_wdata_i == key_byte);
        end

        if (blank_check_done_i && blank_check_erased_i) begin
            st_next.option[1:0] = SEC_UNSECURED;
        end

        // Memory gate: blocked writes vanish, blocked reads give zero
        st_next.acc_blocked = blocked;
        st_next.acc_rdata = blocked ? 8'h00 : mem_rdata_i;
        if (acc_valid_i && acc_mem_i && !blocked && !key_write) begin
            st_next.mem_valid = 1'h1;
            st_next.mem_write = acc_write_i;
            st_next.mem_addr = acc_addr_i;
            st_next.mem_wdata = acc_wdata_i;
            // Flash writes open a command unless protected or unclocked
            st_next.cmd_start = acc_write_i && acc_flash_i && !protected_addr
                && st_reg.ratio[RATIO_LOADED_BIT];
        end

        st_next.debug_en = debug_enable_req_i && !secure;
        st_next.bg_active = background_entry_req_i && (!secure || st_reg.strap_low);
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_reg <= st_rst;
        end else begin
            st_reg <= st_next;
        end
    end

    // ============================================================
    // Outputs
    assign prdata_o = st_reg.prdata;
    assign pready_o = st_reg.pready;
    assign pslverr_o = st_reg.pslverr;
    assign mem_valid_o = st_reg.mem_valid;
    assign mem_write_o = st_reg.mem_write;
    assign mem_addr_o = st_reg.mem_addr;
    assign mem_wdata_o = st_reg.mem_wdata;
    assign acc_rdata_o = st_reg.acc_rdata;
    assign acc_blocked_o = st_reg.acc_blocked;
    assign cmd_start_o = st_reg.cmd_start;
    assign flash_clk_tick_o = div_tick;
    assign op_busy_o = op_busy;
    assign op_done_o = op_done;
    assign debug_enable_o = st_reg.debug_en;
    assign background_active_o = st_reg.bg_active;

    // ============================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_blocked_read_zero: assert property (blocked |=> acc_rdata_o == 8'h00 && !mem_valid_o)
        else $error("blocked access reached memory or returned data");
    a_secure_decode: assert property (debug_enable_o |-> $past(st_reg.option[1:0]) == SEC_UNSECURED)
        else $error("debug enabled under a secure code");
    a_option_loaded: assert property ($fell(reset_i) |-> st_reg.option == $past(nonvolatile_option_byte_i))
        else $error("option byte not copied at reset");
    a_debug_locked: assert property (secure && $past(secure) |-> !debug_enable_o)
        else $error("debug enabled while secure");
    a_bg_strap: assert property (background_active_o && $past(secure) |-> st_reg.strap_low)
        else $error("background entry without strap");
    a_key_no_cmd: assert property (key_write |=> !cmd_start_o && !mem_valid_o)
        else $error("key write started a command");
    a_key_disabled: assert property (!st_reg.option[OPT_BACKDOOR_UNLOCK_ENABLE_BIT] && secure && !blank_check_done_i
        |=> secure)
        else $error("unlock with key disabled");
    a_unlock_match: assert property (apb_write && paddr_i == OFF_CONFIG && !pwdata_i[CFG_COMPARISON_WRITE_ACCESS_BIT]
        && st_reg.comparison_write_access && st_reg.option[OPT_BACKDOOR_UNLOCK_ENABLE_BIT] && st_reg.key_ok && st_reg.key_idx == KEY_COUNT
        |=> !secure ##1 !secure)
        else $error("matching key did not unlock");
    a_debug_key_ignored: assert property (key_write && acc_debug_i |=> $stable(st_reg.key_idx))
        else $error("debug key write counted");
    a_protect_guard: assert property (apb_write && paddr_i == OFF_PROTECT && !apb_debug_i
        |=> $stable(st_reg.protect))
        else $error("software changed protection");
    a_blank_unlock: assert property (blank_check_done_i && blank_check_erased_i |=> !secure)
        else $error("blank check did not unlock");
    a_loaded_flag: assert property (apb_write && paddr_i == OFF_RATIO
        |=> st_reg.ratio[RATIO_LOADED_BIT] [*3])
        else $error("loaded flag not set by write");
    a_cmd_start: assert property (acc_valid_i && acc_write_i && acc_flash_i && acc_mem_i && key_hit
        && !st_reg.comparison_write_access && !blocked && !protected_addr && st_reg.ratio[RATIO_LOADED_BIT]
        |=> cmd_start_o)
        else $error("key address write did not start a command");

    c_key_unlock: cover property (st_reg.comparison_write_access ##1 !st_reg.comparison_write_access && !secure);
    c_blank_unlock: cover property (secure ##1 blank_check_done_i && blank_check_erased_i ##1 !secure);
    c_blocked: cover property (acc_blocked_o);
    c_op_done: cover property (op_done_o);
endmodule

// ==== test/mem_model.sv ====
// Flash and RAM array model standing behind the security gate.
// Assumes reads answer in the request cycle and writes land on the gate's one-cycle memory pulse.
`timescale 1ns/1ns
module mem_model (
    // Clock
    input wire logic clk_i,
    // Array port
    input wire logic [15:0] raddr_i,
    input wire logic valid_i,
    input wire logic write_i,
    input wire logic [15:0] waddr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    // ============================================================
    // Array, seeded so that neighbouring bytes differ
    logic [7:0] mem [256];
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end
    assign rdata_o = mem[raddr_i[7:0]];
    always @(posedge clk_i) begin
        if (valid_i && write_i) begin
            mem[waddr_i[7:0]] <= wdata_i;
        end
    end
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the flash security gate and its clock divider.
// Assumes the memory model behind the gate; the bench plays cpu, debug host and nonvolatile bytes.
`timescale 1ns/1ns
module testbench
    import fsec_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, apb_debug_i = 1'b0;
    logic [7:0] paddr_i = 8'h00, opt = 8'h83, acc_wdata_i = 8'h00, mem_rdata_i, mem_wdata_o, acc_rdata_o;
    logic [31:0] pwdata_i = 32'h0, prdata_o;
    logic pready_o, pslverr_o, strap_pin = 1'b1;
    logic [63:0] key_bytes = 64'h0;
    logic acc_valid_i = 1'b0, acc_write_i = 1'b0, acc_mem_i = 1'b0, acc_flash_i = 1'b0;
    logic acc_secure_src_i = 1'b0, acc_debug_i = 1'b0, acc_d = 1'b0;
    logic [15:0] acc_addr_i = 16'h0, mem_addr_o;
    logic mem_valid_o, mem_write_o, acc_blocked_o, cmd_start_o;
    logic blank_check_done_i = 1'b0, blank_check_erased_i = 1'b0, op_start_i = 1'b0;
    logic [PULSE_W-1:0] op_pulses_i = 16'h0;
    logic flash_clk_tick_o, op_busy_o, op_done_o, debug_enable_o, background_active_o;
    logic debug_enable_req_i = 1'b0, background_entry_req_i = 1'b0;
    int fail_count = 0, num_checks = 0, g;
    logic [32:0] rd_q[$];
    logic [11:0] acc_q[$];
    logic [7:0] seed = 8'h29;
    logic [7:0] div_set[3] = '{8'h03, 8'h41, 8'h00};
    int div_gap[3] = '{4, 16, 1};

    always #5 clk_i = ~clk_i;

    flash_security u_flash_security (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .apb_debug_i(apb_debug_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .nonvolatile_option_byte_i(opt), .nonvolatile_protection_byte_i(8'hff),
        .backdoor_comparison_bytes_i(key_bytes), .background_mode_select_pin_i(strap_pin),
        .acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i), .acc_addr_i(acc_addr_i),
        .acc_wdata_i(acc_wdata_i), .acc_mem_i(acc_mem_i), .acc_flash_i(acc_flash_i),
        .acc_secure_src_i(acc_secure_src_i), .acc_debug_i(acc_debug_i), .mem_rdata_i(mem_rdata_i),
        .mem_valid_o(mem_valid_o), .mem_write_o(mem_write_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .acc_rdata_o(acc_rdata_o), .acc_blocked_o(acc_blocked_o),
        .cmd_start_o(cmd_start_o), .blank_check_done_i(blank_check_done_i),
        .blank_check_erased_i(blank_check_erased_i), .op_start_i(op_start_i), .op_pulses_i(op_pulses_i),
        .flash_clk_tick_o(flash_clk_tick_o), .op_busy_o(op_busy_o), .op_done_o(op_done_o),
        .debug_enable_req_i(debug_enable_req_i), .background_entry_req_i(background_entry_req_i),
        .debug_enable_o(debug_enable_o), .background_active_o(background_active_o));

    mem_model u_mem_model (.clk_i(clk_i), .raddr_i(acc_addr_i), .valid_i(mem_valid_o), .write_i(mem_write_o),
        .waddr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

    // ============================================================
    // Verdict, comparison and helpers
    task automatic print_verdict();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hang();
        fail_count++;
        $display("MISMATCH %0t wait ran out", $time);
        print_verdict();
    endtask

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // ============================================================
    // Bus drivers
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic dbg);
        int n;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= {24'h0, d};
        apb_debug_i <= dbg;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            hang();
        end
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic err = 1'b0);
        rd_q.push_back({err, 24'h0, e});
        apb(1'b0, a, 8'h00, 1'b0);
    endtask

    // Flags are {flash, secure source, debug}; e is {data ignored, mem pulse, command, blocked, data}
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [2:0] f,
                       input logic [11:0] e);
        acc_q.push_back(e);
        acc_valid_i <= 1'b1;
        acc_write_i <= w;
        acc_addr_i <= a;
        acc_wdata_i <= d;
        acc_mem_i <= 1'b1;
        {acc_flash_i, acc_secure_src_i, acc_debug_i} <= f;
        @(posedge clk_i);
        acc_valid_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Byte bad gets a flipped bit; a value of 8 enters the key intact
    task automatic key(input int bad, input logic [2:0] f, input logic [11:0] e);
        apb(1'b1, OFF_CONFIG, 8'h20, 1'b0);
        for (int i = 0; i < KEY_BYTES; i++) begin
            acc(1'b1, KEY_BASE + 16'(i), key_bytes[8*i +: 8] ^ 8'(i == bad), f, e);
        end
        apb(1'b1, OFF_CONFIG, 8'h00, 1'b0);
    endtask

    task automatic rst(input logic [7:0] o, input logic p);
        reset_i <= 1'b1;
        opt <= o;
        strap_pin <= p;
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Cycles between two consecutive flash clock ticks
    task automatic gap(output int n);
        int m;
        m = 0;
        do begin
            @(posedge clk_i);
            m++;
        end while (flash_clk_tick_o !== 1'b1 && m < 200);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (flash_clk_tick_o !== 1'b1 && n < 200);
        if (n >= 200) begin
            hang();
        end
    endtask

    // ============================================================
    // Result monitor
    always @(posedge clk_i) begin
        logic [11:0] e;
        logic [32:0] r;
        if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
            r = rd_q.pop_front();
            cmp(prdata_o, r[31:0]);
            cmp({31'h0, pslverr_o}, {31'h0, r[32]});
        end
        if (acc_d) begin
            e = acc_q.pop_front();
            cmp({20'h0, e[11], mem_valid_o, cmd_start_o, acc_blocked_o, e[11] ? e[7:0] : acc_rdata_o}, {20'h0, e});
        end
        acc_d = acc_valid_i;
    end

    // ============================================================
    // Main sequence
    initial begin
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            key_bytes[8*i +: 8] = seed;
        end
        seed = lfsr(seed);
        rst(8'h83, 1'b1);
        rd(OFF_OPTION, 8'h83);
        rd(OFF_RATIO, 8'h00);
        rd(OFF_PROTECT, 8'hff);
        rd(OFF_STATUS, 8'h01);
        rd(8'h08, 8'h00);
        rd(8'h22, 8'h00, 1'b1);
        debug_enable_req_i <= 1'b1;
        background_entry_req_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        cmp({30'h0, debug_enable_o, background_active_o}, 32'h0);
        acc(1'b0, {8'h00, seed}, 8'h00, 3'b000, 12'h100);
        acc(1'b0, {8'h00, seed}, 8'h00, 3'b011, 12'h100);
        acc(1'b0, {8'h00, seed}, 8'h00, 3'b010, {4'h4, seed ^ 8'h5a});
        acc(1'b1, 16'h00f0, seed, 3'b000, 12'h900);
        acc(1'b0, 16'h00f0, 8'h00, 3'b010, {4'h4, 8'hf0 ^ 8'h5a});
        apb(1'b1, OFF_PROTECT, 8'h00, 1'b0);
        rd(OFF_PROTECT, 8'hff);
        apb(1'b1, OFF_PROTECT, 8'hfe, 1'b1);
        rd(OFF_PROTECT, 8'hfe);
        apb(1'b1, OFF_PROTECT, 8'hff, 1'b1);
        acc(1'b1, KEY_BASE, 8'h11, 3'b110, 12'hc00);
        apb(1'b1, OFF_RATIO, 8'h03, 1'b0);
        rd(OFF_RATIO, 8'h83);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, OFF_RATIO, div_set[i], 1'b0);
            gap(g);
            cmp(g, div_gap[i]);
        end
        apb(1'b1, OFF_RATIO, 8'h01, 1'b0);
        op_pulses_i <= 16'h0003;
        op_start_i <= 1'b1;
        @(posedge clk_i);
        op_start_i <= 1'b0;
        g = 0;
        for (int k = 0; k < 100 && op_done_o !== 1'b1; k++) begin
            @(posedge clk_i);
            g += int'(op_busy_o === 1'b1 && flash_clk_tick_o === 1'b1);
        end
        if (op_done_o !== 1'b1) begin
            hang();
        end
        cmp(g, 3);
        key(3, 3'b110, 12'h800);
        rd(OFF_OPTION, 8'h83);
        key(8, 3'b111, 12'h900);
        rd(OFF_OPTION, 8'h83);
        key(8, 3'b110, 12'h800);
        rd(OFF_OPTION, 8'h82);
        cmp({31'h0, debug_enable_o}, 32'h1);
        acc(1'b0, {8'h00, seed}, 8'h00, 3'b001, {4'h4, seed ^ 8'h5a});
        acc(1'b1, KEY_BASE + 16'h1, 8'h22, 3'b100, 12'he00);
        acc(1'b0, KEY_BASE + 16'h1, 8'h00, 3'b100, 12'h422);
        // Protection from 0xfe00 up covers the key window, so no command opens
        apb(1'b1, OFF_PROTECT, 8'hfc, 1'b1);
        acc(1'b1, KEY_BASE + 16'h2, 8'h33, 3'b100, 12'hc00);
        rst(8'h03, 1'b0);
        repeat (2) @(posedge clk_i);
        cmp({30'h0, debug_enable_o, background_active_o}, 32'h1);
        key(8, 3'b110, 12'h800);
        rd(OFF_OPTION, 8'h03);
        blank_check_erased_i <= 1'b1;
        blank_check_done_i <= 1'b1;
        @(posedge clk_i);
        blank_check_done_i <= 1'b0;
        rd(OFF_OPTION, 8'h02);
        print_verdict();
    end
endmodule
